// ==== src/qdrg_pkg.sv ====
package qdrg_pkg;
  // Register byte offsets
  localparam logic [11:0] OFS_ENABLE = 12'h500;
  localparam logic [11:0] OFS_LED_POL = 12'h504;
  localparam logic [11:0] OFS_INTERVAL = 12'h508;
  localparam logic [11:0] OFS_MOTION = 12'h50c;
  localparam logic [11:0] OFS_RPT = 12'h510;
  localparam logic [11:0] OFS_TOTAL = 12'h514;
  localparam logic [11:0] OFS_SNAP = 12'h518;
  localparam logic [11:0] OFS_LEAD = 12'h540;
  localparam logic [11:0] OFS_TASKS = 12'h600;
  localparam logic [11:0] OFS_IRQ_STAT = 12'h604;
  localparam logic [11:0] OFS_IRQ_MASK = 12'h608;
  // Field positions
  localparam int BIT_ENABLE = 0;
  localparam int BIT_LED_POL = 0;
  localparam int BIT_TASK_RDCLR_ALL = 0;
  localparam int BIT_TASK_RDCLR_TOT = 1;
  localparam int EV_SAMPLE = 0;
  localparam int EV_REPORT = 1;
  localparam int EV_DOUBLE = 2;
  localparam int EV_N = 3;
  // Reset values
  localparam logic RST_ENABLE = 1'b0;
  localparam logic RST_LED_POL = 1'b0;
  localparam logic [3:0] RST_INTERVAL = 4'h0;
  localparam logic [2:0] RST_MOTION = 3'h0;
  localparam logic [15:0] RST_RPT = 16'h0000;
  localparam logic [10:0] RST_TOTAL = 11'h000;
  localparam logic [8:0] RST_LEAD = 9'h000;
  localparam logic [EV_N-1:0] RST_IRQ_MASK = 3'h0;
  // Interval table: 128 us shifted left by the code, code clamped at the top
  localparam logic [3:0] INTERVAL_CODE_MAX = 4'ha;
  localparam logic [17:0] INTERVAL_BASE_US = 18'h00080;
  localparam logic [2:0] MOTION_DOUBLE = 3'h2;
  localparam logic signed [11:0] TOTAL_MAX = 12'sh3ff;
  localparam logic signed [11:0] TOTAL_MIN = -12'sh400;
  // Timebase
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_NS = 1000;
  localparam int CYC_PER_US = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  typedef enum logic {
    QDRG_BUS_IDLE = 1'b0,
    QDRG_BUS_ACK = 1'b1
  } qdrg_bus_t;
endpackage : qdrg_pkg

// ==== src/qdrg_top.sv ====
// Summary of operation
// (RULE1) Setting enable bit 0 hands the phase and LED pins to the decoder; clearing it releases them as GPIO.
// (RULE2) While disabled the decoder neither drives the LED pin nor samples the phase pins.
// (RULE3) The polarity bit picks the LED-on level: 0 means low, 1 means high.
// (RULE4) The interval code 0..10 gives 128 us doubling to 131072 us, and every sample refreshes the motion sample.
// (RULE5) The motion sample reads as a signed two's complement value from -1 to 2, sign giving direction.
// (RULE6) A sample where both phases changed reads as 2, a double transition.
// (RULE7) Report and double-step events come only after the programmed number of samples.
// (RULE8) The transition total sums the signed value of every valid step, double transitions excluded.
// (RULE9) Either read-and-clear task copies the total into the snapshot, range -1024 to 1023.
// (RULE10) The LED is switched on for the programmed lead time before each sample.
// (RULE11) Each sample compares old and new phase pairs: +1 or -1 for one Gray step, 0 for none, double for two.
//
// Decided for this implementation: register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
module qdrg_top #(
  parameter int CYC_PER_US_P = qdrg_pkg::CYC_PER_US
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic [11:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic irq,
  input wire logic phase_a_in,
  input wire logic phase_b_in,
  output logic led_out,
  output logic led_oe,
  output logic pins_owned
);

  typedef struct packed {
    logic enable;
    logic led_pol;
    logic [3:0] interval_code;
    logic [2:0] motion;
    logic [15:0] rpt_lim;
    logic [10:0] total;
    logic [10:0] snap;
    logic [8:0] lead;
    logic [qdrg_pkg::EV_N-1:0] irq_stat;
    logic [qdrg_pkg::EV_N-1:0] irq_mask;
    logic [2:0] sync_a;
    logic [2:0] sync_b;
    logic [1:0] phase;
    logic [1:0] prev;
    logic [15:0] presc;
    logic [17:0] us_cnt;
    logic [15:0] rpt_cnt;
    logic moved_seen;
    logic dbl_seen;
    logic led_out;
    logic led_oe;
    qdrg_pkg::qdrg_bus_t bus_st;
    logic [31:0] rdata;
  } qdrg_state_t;

  qdrg_state_t q_r;
  qdrg_state_t q_nxt;

  localparam logic [15:0] PRESC_LAST = 16'(CYC_PER_US_P - 1);

  function automatic logic [31:0] qdrg_merge(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] be);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    return (old & ~m) | (wd & m);
  endfunction : qdrg_merge

  logic req;
  logic bus_done;
  logic [3:0] code_eff;
  logic [17:0] interval_us;
  logic [17:0] remaining_us;
  logic us_tick;
  logic strobe;
  logic [1:0] diff;
  logic step_single;
  logic step_double;
  logic step_dir;
  logic [2:0] motion_new;
  logic signed [11:0] total_ext;
  logic signed [11:0] total_sum;
  logic [10:0] total_sat;
  logic [15:0] rpt_lim_eff;
  logic rpt_hit;
  logic led_active;
  logic clr_task;
  logic [qdrg_pkg::EV_N-1:0] ev;
  logic [31:0] rd_mux;
  logic [31:0] wr_val;

  assign req = avs_read | avs_write;
  assign bus_done = req && q_r.bus_st == qdrg_pkg::QDRG_BUS_ACK;
  assign avs_waitrequest = req && q_r.bus_st != qdrg_pkg::QDRG_BUS_ACK;
  assign avs_readdata = q_r.rdata;
  assign irq = |(q_r.irq_stat & q_r.irq_mask);
  assign led_out = q_r.led_out;
  assign led_oe = q_r.led_oe;
  assign pins_owned = q_r.enable;
  // Write data merged into the addressed register under the byte lanes
  assign wr_val = qdrg_merge(rd_mux, avs_writedata, avs_byteenable);

  always_comb begin
    // Interval codes above the top code behave as the top code
    code_eff = (q_r.interval_code > qdrg_pkg::INTERVAL_CODE_MAX) ? qdrg_pkg::INTERVAL_CODE_MAX
                                                                : q_r.interval_code;
    interval_us = qdrg_pkg::INTERVAL_BASE_US << code_eff; // [RULE4]
    remaining_us = interval_us - q_r.us_cnt;
    us_tick = q_r.enable && q_r.presc == PRESC_LAST;
    strobe = us_tick && q_r.us_cnt == interval_us - 18'h00001; // [RULE4]
    diff = q_r.prev ^ q_r.phase; // [RULE11]
    step_double = diff == 2'b11; // [RULE6]
    step_single = diff == 2'b01 || diff == 2'b10; // [RULE11]
    step_dir = q_r.prev[1] ^ q_r.phase[0]; // [RULE11]
    if (step_double) begin
      motion_new = qdrg_pkg::MOTION_DOUBLE; // [RULE6]
    end else if (step_single) begin
      motion_new = step_dir ? 3'h1 : 3'h7; // [RULE5]
    end else begin
      motion_new = 3'h0;
    end
    led_active = q_r.enable && remaining_us <= {9'h000, q_r.lead}; // [RULE10]
    rpt_lim_eff = (q_r.rpt_lim == 16'h0000) ? 16'h0001 : q_r.rpt_lim;
    rpt_hit = strobe && q_r.rpt_cnt + 16'h0001 >= rpt_lim_eff; // [RULE7]
    clr_task = bus_done && avs_write && avs_address == qdrg_pkg::OFS_TASKS && avs_byteenable[0]
               && (avs_writedata[qdrg_pkg::BIT_TASK_RDCLR_ALL] || avs_writedata[qdrg_pkg::BIT_TASK_RDCLR_TOT]);
    total_ext = clr_task ? 12'sh000 : {q_r.total[10], q_r.total};
    total_sum = total_ext;
    if (strobe && step_single) begin
      total_sum = step_dir ? total_ext + 12'sh001 : total_ext - 12'sh001; // [RULE8]
    end
    if (total_sum > qdrg_pkg::TOTAL_MAX) begin
      total_sat = qdrg_pkg::TOTAL_MAX[10:0];
    end else if (total_sum < qdrg_pkg::TOTAL_MIN) begin
      total_sat = qdrg_pkg::TOTAL_MIN[10:0];
    end else begin
      total_sat = total_sum[10:0];
    end
    ev = '0;
    ev[qdrg_pkg::EV_SAMPLE] = strobe;
    ev[qdrg_pkg::EV_REPORT] = rpt_hit && (q_r.moved_seen || step_single); // [RULE7]
    ev[qdrg_pkg::EV_DOUBLE] = rpt_hit && (q_r.dbl_seen || step_double); // [RULE7]
    case (avs_address)
      qdrg_pkg::OFS_ENABLE: rd_mux = {31'h00000000, q_r.enable};
      qdrg_pkg::OFS_LED_POL: rd_mux = {31'h00000000, q_r.led_pol};
      qdrg_pkg::OFS_INTERVAL: rd_mux = {28'h0000000, q_r.interval_code};
      qdrg_pkg::OFS_MOTION: rd_mux = {{29{q_r.motion[2]}}, q_r.motion}; // [RULE5]
      qdrg_pkg::OFS_RPT: rd_mux = {16'h0000, q_r.rpt_lim};
      qdrg_pkg::OFS_TOTAL: rd_mux = {{21{q_r.total[10]}}, q_r.total};
      qdrg_pkg::OFS_SNAP: rd_mux = {{21{q_r.snap[10]}}, q_r.snap};
      qdrg_pkg::OFS_LEAD: rd_mux = {23'h000000, q_r.lead};
      qdrg_pkg::OFS_IRQ_STAT: rd_mux = {29'h00000000, q_r.irq_stat};
      qdrg_pkg::OFS_IRQ_MASK: rd_mux = {29'h00000000, q_r.irq_mask};
      default: rd_mux = 32'h00000000;
    endcase
  end

  always_comb begin
    q_nxt = q_r;
    // Phase pins are only sampled while the decoder owns them
    if (q_r.enable) begin
      q_nxt.sync_a = {q_r.sync_a[1:0], phase_a_in}; // [RULE2]
      q_nxt.sync_b = {q_r.sync_b[1:0], phase_b_in}; // [RULE2]
      if (q_r.sync_a[2] == q_r.sync_a[1]) begin
        q_nxt.phase[1] = q_r.sync_a[2];
      end
      if (q_r.sync_b[2] == q_r.sync_b[1]) begin
        q_nxt.phase[0] = q_r.sync_b[2];
      end
      q_nxt.presc = us_tick ? 16'h0000 : q_r.presc + 16'h0001;
      if (us_tick) begin
        q_nxt.us_cnt = strobe ? 18'h00000 : q_r.us_cnt + 18'h00001;
      end
    end else begin
      q_nxt.presc = 16'h0000;
      q_nxt.us_cnt = 18'h00000;
      q_nxt.rpt_cnt = 16'h0000;
      q_nxt.moved_seen = 1'b0;
      q_nxt.dbl_seen = 1'b0;
      q_nxt.prev = q_r.phase;
    end
    if (strobe) begin
      q_nxt.motion = motion_new; // [RULE4]
      q_nxt.prev = q_r.phase; // [RULE11]
      if (rpt_hit) begin
        q_nxt.rpt_cnt = 16'h0000;
        q_nxt.moved_seen = 1'b0;
        q_nxt.dbl_seen = 1'b0;
      end else begin
        q_nxt.rpt_cnt = q_r.rpt_cnt + 16'h0001;
        q_nxt.moved_seen = q_r.moved_seen | step_single;
        q_nxt.dbl_seen = q_r.dbl_seen | step_double;
      end
    end
    q_nxt.total = total_sat; // [RULE8]
    if (clr_task) begin
      q_nxt.snap = q_r.total; // [RULE9]
    end
    q_nxt.led_oe = q_r.enable; // [RULE1]
    if (q_r.enable) begin
      q_nxt.led_out = led_active ? q_r.led_pol : ~q_r.led_pol; // [RULE3]
    end else begin
      q_nxt.led_out = 1'b0; // [RULE2]
    end
    q_nxt.irq_stat = q_r.irq_stat | ev;
    case (q_r.bus_st)
      qdrg_pkg::QDRG_BUS_IDLE: begin
        if (req) begin
          q_nxt.rdata = avs_read ? rd_mux : 32'h00000000;
          q_nxt.bus_st = qdrg_pkg::QDRG_BUS_ACK;
        end
      end
      qdrg_pkg::QDRG_BUS_ACK: begin
        q_nxt.bus_st = qdrg_pkg::QDRG_BUS_IDLE;
        if (req && avs_read && avs_address == qdrg_pkg::OFS_IRQ_STAT) begin
          // Clear only what the read returned; a new event still sets
          q_nxt.irq_stat = (q_r.irq_stat & ~q_r.rdata[qdrg_pkg::EV_N-1:0]) | ev;
        end
        if (req && avs_write) begin
          case (avs_address)
            qdrg_pkg::OFS_ENABLE: begin
              q_nxt.enable = wr_val[qdrg_pkg::BIT_ENABLE]; // [RULE1]
            end
            qdrg_pkg::OFS_LED_POL: begin
              q_nxt.led_pol = wr_val[qdrg_pkg::BIT_LED_POL]; // [RULE3]
            end
            qdrg_pkg::OFS_INTERVAL: begin
              q_nxt.interval_code = wr_val[3:0];
            end
            qdrg_pkg::OFS_RPT: begin
              q_nxt.rpt_lim = wr_val[15:0];
            end
            qdrg_pkg::OFS_LEAD: begin
              q_nxt.lead = wr_val[8:0];
            end
            qdrg_pkg::OFS_IRQ_MASK: begin
              q_nxt.irq_mask = wr_val[qdrg_pkg::EV_N-1:0];
            end
            default: begin
            end
          endcase
        end
      end
      default: q_nxt.bus_st = qdrg_pkg::QDRG_BUS_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      q_r <= '0;
      q_r.enable <= qdrg_pkg::RST_ENABLE;
      q_r.led_pol <= qdrg_pkg::RST_LED_POL;
      q_r.interval_code <= qdrg_pkg::RST_INTERVAL;
      q_r.motion <= qdrg_pkg::RST_MOTION;
      q_r.rpt_lim <= qdrg_pkg::RST_RPT;
      q_r.total <= qdrg_pkg::RST_TOTAL;
      q_r.lead <= qdrg_pkg::RST_LEAD;
      q_r.irq_mask <= qdrg_pkg::RST_IRQ_MASK;
      q_r.bus_st <= qdrg_pkg::QDRG_BUS_IDLE;
    end else if (clk_en) begin
      q_r <= q_nxt;
    end
  end

  AST_LED_RELEASE: assert property (@(posedge sys_clk) disable iff (rst)
    clk_en && !q_r.enable |=> !led_oe && !led_out) else $error("LED pin driven while disabled"); // [RULE1]
  AST_NO_SAMPLE_OFF: assert property (@(posedge sys_clk) disable iff (rst)
    !q_r.enable && clk_en |=> $stable(q_r.motion) && $stable(q_r.sync_a)) else $error("Sampled while disabled"); // [RULE2]
  AST_LED_LEVEL: assert property (@(posedge sys_clk) disable iff (rst)
    clk_en && q_r.enable && !led_active |=> led_out == !$past(q_r.led_pol)) else $error("LED idle level wrong"); // [RULE3]
  AST_INTERVAL: assert property (@(posedge sys_clk) disable iff (rst)
    strobe |-> q_r.us_cnt == (qdrg_pkg::INTERVAL_BASE_US << code_eff) - 18'h00001) else $error("Sample interval wrong"); // [RULE4]
  AST_MOTION_RANGE: assert property (@(posedge sys_clk) disable iff (rst)
    q_r.motion inside {3'h7, 3'h0, 3'h1, 3'h2}) else $error("Motion sample out of range"); // [RULE5]
  AST_DOUBLE: assert property (@(posedge sys_clk) disable iff (rst)
    clk_en && strobe && (q_r.prev ^ q_r.phase) == 2'b11 |=> q_r.motion == 3'h2) else $error("Double step not flagged"); // [RULE6]
  AST_REPORT_GATE: assert property (@(posedge sys_clk) disable iff (rst)
    ev[qdrg_pkg::EV_REPORT] || ev[qdrg_pkg::EV_DOUBLE] |-> strobe && q_r.rpt_cnt + 16'h0001 >= rpt_lim_eff)
    else $error("Report event before count"); // [RULE7]
  AST_TOTAL_STEP: assert property (@(posedge sys_clk) disable iff (rst)
    clk_en && strobe && step_double && !clr_task |=> $stable(q_r.total)) else $error("Double step counted"); // [RULE8]
  AST_SNAPSHOT: assert property (@(posedge sys_clk) disable iff (rst) // [RULE9]
    clk_en && clr_task |=> q_r.snap == $past(q_r.total) && q_r.total inside {11'h000, 11'h001, 11'h7ff})
    else $error("Snapshot not taken");
  AST_LED_LEAD: assert property (@(posedge sys_clk) disable iff (rst)
    clk_en && strobe && q_r.lead != 9'h000 |-> q_r.led_out == q_r.led_pol) else $error("LED not on at sample"); // [RULE10]
  AST_STEP_VALUE: assert property (@(posedge sys_clk) disable iff (rst)
    clk_en && strobe && step_single |=> q_r.motion == 3'h1 || q_r.motion == 3'h7) else $error("Single step value wrong"); // [RULE11]
  AST_OE_FOLLOWS: assert property (@(posedge sys_clk) disable iff (rst) // [RULE1]
    clk_en |=> led_oe == $past(pins_owned)) else $error("LED enable does not follow ownership");
  AST_PHASE_HOLD: assert property (@(posedge sys_clk) disable iff (rst) // [RULE2]
    clk_en && !q_r.enable |=> $stable(q_r.phase) && $stable(q_r.sync_b)) else $error("Phase moved while off");
  AST_LED_ON_LEVEL: assert property (@(posedge sys_clk) disable iff (rst) // [RULE3]
    clk_en && led_active |=> led_out == $past(q_r.led_pol)) else $error("LED active level wrong");

endmodule : qdrg_top
`default_nettype wire

// ==== verification/qdrg_encoder_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module qdrg_encoder_model (
  input wire logic sys_clk,
  input wire logic step_req,
  input wire logic [1:0] step_kind,
  output logic phase_a,
  output logic phase_b
);
  logic [1:0] pos_r = 2'h0;
  // Kind 1 forward, 2 back, 3 jumps two positions between samples
  always @(posedge sys_clk) begin
    if (step_req) begin
      pos_r <= pos_r + ((step_kind == 2'h2) ? 2'h3 : (step_kind == 2'h3) ? 2'h2 : step_kind);
    end
  end
  // Gray order 00, 01, 11, 10 going forward, phase a is the high bit
  assign phase_a = pos_r[1];
  assign phase_b = pos_r[1] ^ pos_r[0];
endmodule : qdrg_encoder_model
`default_nettype wire

// ==== verification/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic sys_clk, rst, avs_read, avs_write, avs_waitrequest, irq, led_out, led_oe, pins_owned;
  logic step_req, phase_a, phase_b, clk_en;
  logic [1:0] step_kind;
  logic [11:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, total;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  logic [7:0] lfsr_r;
  int n_mismatch, checks;
  localparam logic [11:0] RST_OFS [8] = '{qdrg_pkg::OFS_ENABLE, qdrg_pkg::OFS_LED_POL, qdrg_pkg::OFS_INTERVAL,
    qdrg_pkg::OFS_MOTION, qdrg_pkg::OFS_RPT, qdrg_pkg::OFS_TOTAL, qdrg_pkg::OFS_SNAP, 12'h700};

  qdrg_top #(.CYC_PER_US_P(2)) u_dut (.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq), .phase_a_in(phase_a),
    .phase_b_in(phase_b), .led_out(led_out), .led_oe(led_oe), .pins_owned(pins_owned));
  qdrg_encoder_model u_enc (.sys_clk(sys_clk), .step_req(step_req), .step_kind(step_kind), .phase_a(phase_a),
    .phase_b(phase_b));

  task automatic print_verdict();
    $display("Counts: %0d mismatches in %0d checks", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : print_verdict

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] msk);
    checks++;
    if (((got ^ exp) & msk) !== 32'h0) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h mask %h", $time, got, exp, msk);
    end
  endtask : cmp

  task automatic hang();
    n_mismatch++;
    $display("wrong value at %0t: wait ran out", $time);
    print_verdict();
  endtask : hang

  // One Avalon transfer; the request stands until waitrequest is seen low
  task automatic bus(input logic is_rd, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge sys_clk);
    avs_read <= is_rd;
    avs_write <= !is_rd;
    avs_address <= a;
    avs_writedata <= is_rd ? 32'h0 : d;
    for (k = 0; k < 50; k++) begin
      @(posedge sys_clk);
      if (avs_waitrequest === 1'b0) break;
    end
    if (k == 50) hang();
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b0, a, d);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    bus(1'b1, a, 32'h0);
  endtask : rd

  task automatic wait_irq(output int n);
    for (n = 1; n < 3000; n++) begin
      @(posedge sys_clk);
      if (irq === 1'b1) break;
    end
    if (n == 3000) hang();
  endtask : wait_irq

  task automatic smp(input logic [31:0] e, input logic [31:0] m);
    int n;
    wait_irq(n);
    rd(qdrg_pkg::OFS_IRQ_STAT, e, m);
  endtask : smp

  task automatic step(input logic [1:0] k);
    @(posedge sys_clk);
    step_req <= 1'b1;
    step_kind <= k;
    @(posedge sys_clk);
    step_req <= 1'b0;
  endtask : step

  function automatic logic [31:0] mot(input logic [1:0] k);
    return (k == 2'h1) ? 32'h1 : (k == 2'h2) ? 32'hffffffff : (k == 2'h3) ? 32'h2 : 32'h0;
  endfunction : mot

  function automatic logic [7:0] lfsr_next(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : lfsr_next

  // Each completed read is compared against the oldest note
  always @(posedge sys_clk) begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
      cmp(avs_readdata, exp_q.pop_front(), msk_q.pop_front());
    end
  end

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  initial begin
    int i, n;
    logic [1:0] k;
    rst = 1'b1;
    clk_en = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 12'h0;
    avs_writedata = 32'h0;
    step_req = 1'b0;
    step_kind = 2'h0;
    lfsr_r = 8'h57;
    total = 32'h0;
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    for (i = 0; i < 8; i++) rd(RST_OFS[i], 32'h0, 32'hffffffff);
    cmp({30'h0, pins_owned, led_oe}, 32'h0, 32'h3);
    wr(qdrg_pkg::OFS_RPT, 32'hffff);
    wr(qdrg_pkg::OFS_IRQ_MASK, 32'h1);
    wr(qdrg_pkg::OFS_ENABLE, 32'h1);
    rd(qdrg_pkg::OFS_ENABLE, 32'h1, 32'hffffffff);
    repeat (2) @(posedge sys_clk);
    cmp({30'h0, pins_owned, led_oe}, 32'h3, 32'h3);
    for (i = 0; i < 4; i++) begin
      wr(qdrg_pkg::OFS_LED_POL, {31'h0, i[0]});
      wr(qdrg_pkg::OFS_LEAD, i[1] ? 32'h1ff : 32'h0);
      smp(32'h1, 32'h7);
      cmp({31'h0, led_out}, {31'h0, i[1] ? i[0] : !i[0]}, 32'h1);
    end
    for (i = 0; i < 12; i++) begin
      lfsr_r = lfsr_next(lfsr_r);
      k = (i < 8) ? lfsr_r[1:0] : 2'(i - 8);
      if (i == 8) begin
        wr(qdrg_pkg::OFS_RPT, 32'h1);
        smp(32'h0, 32'h0);
      end
      step(k);
      smp((i < 8) ? 32'h1 : {29'h0, k == 2'h3, k == 2'h1 || k == 2'h2, 1'b1}, 32'h7);
      rd(qdrg_pkg::OFS_MOTION, mot(k), 32'hffffffff);
      if (k != 2'h3) total = total + mot(k);
    end
    rd(qdrg_pkg::OFS_TOTAL, total, 32'hffffffff);
    wr(qdrg_pkg::OFS_TASKS, 32'h1);
    rd(qdrg_pkg::OFS_SNAP, total, 32'hffffffff);
    rd(qdrg_pkg::OFS_TOTAL, 32'h0, 32'hffffffff);
    smp(32'h1, 32'h7);
    step(2'h2);
    smp(32'h3, 32'h7);
    wr(qdrg_pkg::OFS_TASKS, 32'h2);
    rd(qdrg_pkg::OFS_SNAP, 32'hffffffff, 32'hffffffff);
    wr(qdrg_pkg::OFS_IRQ_MASK, 32'h0);
    repeat (300) @(posedge sys_clk);
    cmp({31'h0, irq}, 32'h0, 32'h1);
    wr(qdrg_pkg::OFS_IRQ_MASK, 32'h1);
    repeat (2) @(posedge sys_clk);
    cmp({31'h0, irq}, 32'h1, 32'h1);
    rd(qdrg_pkg::OFS_IRQ_STAT, 32'h1, 32'h1);
    repeat (2) @(posedge sys_clk);
    cmp({31'h0, irq}, 32'h0, 32'h1);
    // A frozen block must not reach its next sample
    clk_en <= 1'b0;
    repeat (600) @(posedge sys_clk);
    cmp({31'h0, irq}, 32'h0, 32'h1);
    clk_en <= 1'b1;
    for (i = 0; i < 3; i++) begin
      wr(qdrg_pkg::OFS_INTERVAL, 32'(i));
      smp(32'h1, 32'h7);
      wait_irq(n);
      rd(qdrg_pkg::OFS_IRQ_STAT, 32'h1, 32'h7);
      wait_irq(n);
      cmp(32'(n + 3), 32'h100 << i, 32'hffffffff);
    end
    wr(qdrg_pkg::OFS_ENABLE, 32'h0);
    step(2'h1);
    repeat (3) @(posedge sys_clk);
    cmp({30'h0, pins_owned, led_oe}, 32'h0, 32'h3);
    repeat (1200) @(posedge sys_clk);
    rd(qdrg_pkg::OFS_MOTION, 32'h0, 32'hffffffff);
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
